/* File: hdl/casm_pkg.sv */
// Constants for the codec audio serial master.
// Assumes a single system clock; all rates are given in kHz.
package casm_pkg;
  // ---------------------------------------------------------------
  // Rates
  // ---------------------------------------------------------------
  localparam int unsigned SYS_CLK_KHZ = 20000;
  localparam int unsigned FS_KHZ = 8;
  localparam int unsigned MCLK_PER_FS = 256;
  localparam int unsigned BCLK_PER_FS = 32;
  localparam int unsigned MCLK_KHZ = MCLK_PER_FS * FS_KHZ;
  localparam int unsigned BCLK_KHZ = BCLK_PER_FS * FS_KHZ;
  // Main clock half-period ticks per system clock, as a ratio
  localparam int unsigned ACC_W = 15;
  localparam logic [14:0] ACC_STEP = 15'(2 * MCLK_KHZ);
  localparam logic [14:0] ACC_MOD = 15'(SYS_CLK_KHZ);
  // ---------------------------------------------------------------
  // Frame layout
  // ---------------------------------------------------------------
  localparam int unsigned SAMPLE_W = 16;
  localparam int unsigned PHASE_W = 9;
  localparam logic [3:0] HALF_RISE = 4'h7;
  localparam logic [3:0] HALF_FALL = 4'hF;
  localparam logic [3:0] SLOT_LOAD = 4'h1;
  localparam logic [3:0] SLOT_DONE = 4'h0;
  localparam logic [4:0] SLOT_LEFT_DONE = 5'h10;
  localparam logic [4:0] SLOT_RIGHT_DONE = 5'h00;
  localparam logic [4:0] SLOT_LEFT_LOAD = 5'h01;
  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [14:0] ACC_RST = 15'h0000;
  localparam logic [8:0] PHASE_RST = 9'h000;
  localparam logic [15:0] SAMPLE_RST = 16'h0000;
endpackage

/* File: hdl/casm_codec_audio_serial_master.sv */
// Audio serial port master toward an external codec, standard framing.
// Assumes clk_sys at 20 MHz and a codec acting as serial slave.
// Summary of operation
// - Device drives bit clock and word select
// - Continuous main clock at 256 times sample rate
// - Standard framing, 8 kHz samples, 256 kHz bit clock
// - Two 16-bit channels, 32 bit clocks per frame
// - Bit clock duty cycle fifty percent
// - Received left samples stored as microphone buffer
`timescale 1ns/1ps
`default_nettype none
module casm_codec_audio_serial_master #(
  parameter int unsigned SAMPLE_W = casm_pkg::SAMPLE_W
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [SAMPLE_W-1:0] tx_left,
  input wire logic [SAMPLE_W-1:0] tx_right,
  output logic tx_take,
  output logic [SAMPLE_W-1:0] mic_left,
  output logic [SAMPLE_W-1:0] rx_right,
  output logic rx_valid,
  output logic main_clock_out,
  output logic bit_clock_out,
  output logic word_select_out,
  output logic serial_data_out,
  input wire logic serial_data_in
);
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic [casm_pkg::ACC_W-1:0] acc_q, acc_d;
  logic [casm_pkg::PHASE_W-1:0] phase_q, phase_d;
  logic ws_q, ws_d;
  logic sdo_q, sdo_d;
  logic [SAMPLE_W-1:0] tx_sh_q, tx_sh_d;
  logic [SAMPLE_W-1:0] tx_hold_q, tx_hold_d;
  logic [SAMPLE_W-1:0] rx_sh_q, rx_sh_d;
  logic [SAMPLE_W-1:0] mic_q, mic_d;
  logic [SAMPLE_W-1:0] rxr_q, rxr_d;
  logic rxv_q, rxv_d;
  logic sdi_m_q, sdi_m_d;
  logic sdi_s_q, sdi_s_d;

  // ---------------------------------------------------------------
  // Decoded timing
  // ---------------------------------------------------------------
  logic [casm_pkg::ACC_W-1:0] acc_sum;
  logic tick;
  logic fall_edge;
  logic rise_edge;
  logic [4:0] slot_next;
  logic [4:0] slot_now;
  logic [SAMPLE_W-1:0] rx_word;
  logic load;
  logic load_left;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Bit slot within the frame for a phase count
  function automatic logic [4:0] slot_of(
    input logic [casm_pkg::PHASE_W-1:0] phase
  );
    return phase[casm_pkg::PHASE_W-1 -: 5];
  endfunction

  // Half-bit position within the slot for a phase count
  function automatic logic [3:0] half_of(
    input logic [casm_pkg::PHASE_W-1:0] phase
  );
    return phase[3:0];
  endfunction

  // Shift a word up by one, entering a new bit at the bottom
  function automatic logic [SAMPLE_W-1:0] shift_in(
    input logic [SAMPLE_W-1:0] word,
    input logic bit_in
  );
    return {word[SAMPLE_W-2:0], bit_in};
  endfunction

  // ---------------------------------------------------------------
  // Rate generator
  // ---------------------------------------------------------------
  // Fractional divider: exact on average, edges jitter by one cycle
  always_comb begin
    acc_sum = acc_q + casm_pkg::ACC_STEP;
    tick = (acc_sum >= casm_pkg::ACC_MOD);
    acc_d = tick ? acc_sum - casm_pkg::ACC_MOD : acc_sum;
    phase_d = tick ? phase_q + 9'h001 : phase_q;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      acc_q <= casm_pkg::ACC_RST;
      phase_q <= casm_pkg::PHASE_RST;
    end else begin
      acc_q <= acc_d;
      phase_q <= phase_d;
    end
  end

  // ---------------------------------------------------------------
  // Bit clock edges
  // ---------------------------------------------------------------
  always_comb begin
    fall_edge = tick && (half_of(phase_q) == casm_pkg::HALF_FALL);
    rise_edge = tick && (half_of(phase_q) == casm_pkg::HALF_RISE);
    slot_next = slot_of(phase_d);
    slot_now = slot_of(phase_q);
  end

  // ---------------------------------------------------------------
  // Transmit side
  // ---------------------------------------------------------------
  always_comb begin
    ws_d = ws_q;
    sdo_d = sdo_q;
    tx_sh_d = tx_sh_q;
    tx_hold_d = tx_hold_q;
    load = 1'b0;
    load_left = 1'b0;
    tx_take = 1'b0;
    // Select and data move only on the falling bit clock edge
    if (fall_edge) begin
      // Select leads each word by one bit: high for slots 16 to 31
      ws_d = slot_next[4];
      load = (slot_next[3:0] == casm_pkg::SLOT_LOAD);
      load_left = (slot_next == casm_pkg::SLOT_LEFT_LOAD);
      if (load_left) begin
        // Right word is held so both halves come from one frame
        tx_take = 1'b1;
        tx_hold_d = tx_right;
        sdo_d = tx_left[SAMPLE_W-1];
        tx_sh_d = shift_in(tx_left, 1'b0);
      end else if (load) begin
        sdo_d = tx_hold_q[SAMPLE_W-1];
        tx_sh_d = shift_in(tx_hold_q, 1'b0);
      end else begin
        sdo_d = tx_sh_q[SAMPLE_W-1];
        tx_sh_d = shift_in(tx_sh_q, 1'b0);
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ws_q <= 1'b0;
      sdo_q <= 1'b0;
      tx_sh_q <= casm_pkg::SAMPLE_RST;
      tx_hold_q <= casm_pkg::SAMPLE_RST;
    end else begin
      ws_q <= ws_d;
      sdo_q <= sdo_d;
      tx_sh_q <= tx_sh_d;
      tx_hold_q <= tx_hold_d;
    end
  end

  // ---------------------------------------------------------------
  // Input synchroniser
  // ---------------------------------------------------------------
  // Codec data is launched off our bit clock but reaches us unclocked
  always_comb begin
    sdi_m_d = serial_data_in;
    sdi_s_d = sdi_m_q;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sdi_m_q <= 1'b0;
      sdi_s_q <= 1'b0;
    end else begin
      sdi_m_q <= sdi_m_d;
      sdi_s_q <= sdi_s_d;
    end
  end

  // ---------------------------------------------------------------
  // Receive side
  // ---------------------------------------------------------------
  // Capture on the rising bit clock edge, mid-bit
  always_comb begin
    rx_word = shift_in(rx_sh_q, sdi_s_q);
    rx_sh_d = rx_sh_q;
    mic_d = mic_q;
    rxr_d = rxr_q;
    rxv_d = 1'b0;
    if (rise_edge) begin
      rx_sh_d = rx_word;
      if (slot_now == casm_pkg::SLOT_LEFT_DONE) begin
        mic_d = rx_word;
      end else if (slot_now == casm_pkg::SLOT_RIGHT_DONE) begin
        rxr_d = rx_word;
        rxv_d = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rx_sh_q <= casm_pkg::SAMPLE_RST;
      mic_q <= casm_pkg::SAMPLE_RST;
      rxr_q <= casm_pkg::SAMPLE_RST;
      rxv_q <= 1'b0;
    end else begin
      rx_sh_q <= rx_sh_d;
      mic_q <= mic_d;
      rxr_q <= rxr_d;
      rxv_q <= rxv_d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------

  // Clocks come straight from the phase counter flops
  assign main_clock_out = phase_q[0];
  assign bit_clock_out = phase_q[3];
  assign word_select_out = ws_q;
  assign serial_data_out = sdo_q;
  assign mic_left = mic_q;
  assign rx_right = rxr_q;
  assign rx_valid = rxv_q;
endmodule // casm_codec_audio_serial_master
`default_nettype wire

/* File: testbench/casm_properties.sv */
// Port checker for the audio serial master.
// Assumes one 20 MHz clk_sys domain with synchronous rst.
`timescale 1ns/1ps
`default_nettype none
module casm_properties (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic tx_take,
  input wire logic [15:0] tx_left,
  input wire logic [15:0] mic_left,
  input wire logic main_clock_out,
  input wire logic bit_clock_out,
  input wire logic word_select_out,
  input wire logic serial_data_out
);
  // ----
  // Clock and frame checks
  // ----
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic [11:0] gap_q;
  always_ff @(posedge clk_sys)
    gap_q <= (rst || tx_take) ? 12'h000 : gap_q + 12'h001;
  sequence mclk_hold;
    $stable(main_clock_out)[*3] ##[1:2] $changed(main_clock_out);
  endsequence
  chk_mclk_period: assert property ($changed(main_clock_out) |=>
    mclk_hold) else $error("main clock half period wrong");
  chk_bclk_half: assert property ($changed(bit_clock_out) |->
    $changed(main_clock_out) ##[39:40] $changed(bit_clock_out))
    else $error("bit clock half period wrong");
  chk_take_period: assert property (tx_take |->
    gap_q == 12'h9C3 || gap_q < 12'h064) else $error("frame length wrong");
  chk_ws_take: assert property ($fell(word_select_out) |->
    ##[76:80] tx_take) else $error("left slot not after select low");
  chk_line_edges: assert property ($changed(word_select_out) ||
    $changed(serial_data_out) |-> $fell(bit_clock_out))
    else $error("line moved off bit clock fall");
  chk_msb_first: assert property (tx_take |=>
    serial_data_out == $past(tx_left[15])) else $error("first bit not MSB");
  chk_left_store: assert property ($changed(mic_left) |->
    word_select_out) else $error("left word stored at wrong time");
endmodule // casm_properties
bind casm_codec_audio_serial_master casm_properties chk (.clk_sys, .rst,
  .tx_take, .tx_left, .mic_left, .main_clock_out, .bit_clock_out,
  .word_select_out, .serial_data_out);
`default_nettype wire

/* File: testbench/casm_codec_model.sv */
// Behavioural codec slave sending a fixed word each frame.
// Assumes the master owns bit clock and word select.
`timescale 1ns/1ps
`default_nettype none
module casm_codec_model (
  input wire logic bit_clock_out,
  input wire logic word_select_out,
  input wire logic serial_data_out,
  output logic serial_data_in,
  output logic [31:0] got_q
);
  // ----
  // Follows the master clocks only
  // ----
  logic [31:0] sr_q = 32'h0000_0000;
  logic [31:0] rx_q = 32'h0000_0000;
  logic wsp_q = 1'b0;
  initial serial_data_in = 1'b0;
  always @(posedge bit_clock_out or negedge bit_clock_out) begin
    if (bit_clock_out) begin
      wsp_q <= word_select_out;
      rx_q <= {rx_q[30:0], serial_data_out};
      if (wsp_q && !word_select_out) begin
        sr_q <= 32'hA5C3_5A3C;
        got_q <= rx_q;
      end
    end else begin
      serial_data_in <= sr_q[31];
      sr_q <= {sr_q[30:0], ~sr_q[31]};
    end
  end
endmodule // casm_codec_model
`default_nettype wire

/* File: testbench/tb_top.sv */
// Bench top: master, codec model and bound checker.
// Assumes 20 MHz clk_sys; one frame is 2500 cycles.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk_sys, rst, tx_take, rx_valid, main_clock_out, bit_clock_out;
  logic word_select_out, serial_data_out, serial_data_in;
  logic [15:0] tx_left, tx_right, mic_left, rx_right;
  logic [31:0] got_q;
  int err_count, n_tests;
  casm_codec_audio_serial_master dut (.clk_sys, .rst, .tx_left, .tx_right,
    .tx_take, .mic_left, .rx_right, .rx_valid, .main_clock_out,
    .bit_clock_out, .word_select_out, .serial_data_out, .serial_data_in);
  casm_codec_model codec (.bit_clock_out, .word_select_out,
    .serial_data_out, .serial_data_in, .got_q);
  // ----
  // Checks and scenarios
  // ----
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic close_out;
    $display("mismatches %0d checks %0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic wait_rx(input int n);
    for (int k = 0; k < 11000 && n > 0; k++) begin
      @(negedge clk_sys);
      if (rx_valid === 1'b1) n--;
    end
    cmp(32'(n), 32'h0000_0000);
  endtask
  task automatic t_stream;
    tx_left <= 16'h8001;
    tx_right <= 16'h7FFE;
    wait_rx(3);
    cmp({mic_left, rx_right}, 32'hA5C3_5A3C);
    cmp({1'b0, got_q[30:0]}, {1'b0, 16'h8001, 15'h3FFF});
  endtask
  task automatic t_reset;
    repeat (900) @(posedge clk_sys);
    rst <= 1'b1;
    tx_left <= 16'h1234;
    tx_right <= 16'hFFFF;
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    cmp({main_clock_out, bit_clock_out, mic_left}, 32'h0000_0000);
    @(posedge clk_sys);
    rst <= 1'b0;
    wait_rx(3);
    cmp({1'b0, got_q[30:0]}, {1'b0, 16'h1234, 15'h7FFF});
    cmp({mic_left, rx_right}, 32'hA5C3_5A3C);
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  initial begin
    rst = 1'b1;
    tx_left = 16'h0000;
    tx_right = 16'h0000;
    err_count = 0;
    n_tests = 0;
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    t_stream();
    t_reset();
    close_out();
  end
  initial begin
    #1500000;
    err_count++;
    close_out();
  end
endmodule // tb_top
`default_nettype wire
